// *** rtl/sdpr_consts.svh ***
// constants for the synchronous dual-port ram port
`ifndef SDPR_CONSTS_SVH
`define SDPR_CONSTS_SVH
`define SDPR_ADDR_W 15
`define SDPR_DATA_W 18
`define SDPR_BYTE_W 9
`define SDPR_DEPTH 32768
`define SDPR_UPPER_LSB 9
`define SDPR_ADDR_RST 15'h0000
`define SDPR_WAKE_CYCLES 2'h2
`endif

// *** rtl/sdpr_pkg.sv ***
// types shared by the dual-port ram port
package sdpr_pkg;
	typedef enum logic [2:0] {
		SDPR_ST_STANDBY = 3'b001,
		SDPR_ST_WAKE = 3'b010,
		SDPR_ST_ACTIVE = 3'b100
	} sdpr_pwr_t;
endpackage

// *** rtl/sdpr_addr_counter.sv ***
// address counter: load, advance, hold and clear
`timescale 1ns/1ps
`include "sdpr_consts.svh"
module sdpr_addr_counter #(
	parameter int ADDR_W = `SDPR_ADDR_W
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [ADDR_W-1:0] i_ext_addr,
	input wire logic i_addr_load_n,
	input wire logic i_count_advance_n,
	input wire logic i_count_clear_n,
	output logic [ADDR_W-1:0] o_access_addr
);
	typedef struct packed {
		logic [ADDR_W-1:0] cnt;
	} sdpr_cnt_t;
	sdpr_cnt_t st_reg;
	sdpr_cnt_t st_next;
	logic [ADDR_W-1:0] base;

	// access address is picked combinationally so clear and advance cost no cycle
	always_comb begin
		st_next = st_reg;
		base = i_addr_load_n ? st_reg.cnt : i_ext_addr;
		if (!i_count_clear_n) begin
			st_next.cnt = '0;
		end else if (!i_count_advance_n) begin
			st_next.cnt = base + ADDR_W'(1);
		end else begin
			st_next.cnt = base;
		end
	end
	assign o_access_addr = st_next.cnt;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule // sdpr_addr_counter

// *** rtl/sdpr_mem_array.sv ***
// word storage written by two ports, read combinationally by index
`timescale 1ns/1ps
`include "sdpr_consts.svh"
module sdpr_mem_array #(
	parameter int ADDR_W = `SDPR_ADDR_W,
	parameter int DATA_W = `SDPR_DATA_W,
	parameter int DEPTH = `SDPR_DEPTH
) (
	input wire logic i_clk,
	input wire logic [1:0] i_we,
	input wire logic [1:0] i_upper_we,
	input wire logic [ADDR_W-1:0] i_waddr [2],
	input wire logic [DATA_W-1:0] i_wdata [2],
	input wire logic [ADDR_W-1:0] i_raddr [2],
	output logic [DATA_W-1:0] o_rdata [2]
);
	localparam int HB = DATA_W / 2;
	logic [DATA_W-1:0] mem [DEPTH];

	// no reset on storage, as in a real ram; port b written last on collision
	always_ff @(posedge i_clk) begin
		for (int p = 0; p < 2; p++) begin
			if (i_we[p]) begin
				mem[i_waddr[p]][HB-1:0] <= i_wdata[p][HB-1:0];
			end
			if (i_upper_we[p]) begin
				mem[i_waddr[p]][DATA_W-1:HB] <= i_wdata[p][DATA_W-1:HB];
			end
		end
	end
	assign o_rdata[0] = mem[i_raddr[0]];
	assign o_rdata[1] = mem[i_raddr[1]];
endmodule // sdpr_mem_array

// *** rtl/sdpr_dual_port_ram.sv ***
// synchronous dual-port ram: two identical registered ports over one array
// How it works
// - all inputs but output enable and latency strap sampled on rising edge
// - deselect or either byte disable tri-states outputs after the second edge (third when pipelined)
// - each byte lane enabled independently by its own byte enable
// - address load low captures external address every edge
// - access address is external when loading, counter when not
// - advance low increments address; write uses incremented address
// - no load and no advance holds address and read data
// - counter clear costs no cycle; same-cycle access hits address zero
// - flow-through output state follows the previous cycle's registered controls
// - registers update on rising edge; write is self-timed
// - one deselected cycle puts the port into standby
// - pipelined port needs two selected cycles to reactivate outputs
// - cross-port write becomes readable after the write edge
// - both ports identical, either may write or read
// - latency strap low gives flow-through output
// - latency strap high gives pipelined output, chosen per port
// - latency strap is a static asynchronous level
`timescale 1ns/1ps
`include "sdpr_consts.svh"
module sdpr_dual_port_ram
	import sdpr_pkg::*;
#(
	parameter int ADDR_W = `SDPR_ADDR_W,
	parameter int DATA_W = `SDPR_DATA_W,
	parameter int DEPTH = `SDPR_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [1:0] i_primary_select_n,
	input wire logic [1:0] i_secondary_select,
	input wire logic [1:0] i_read_write,
	input wire logic [1:0] i_upper_byte_en_n,
	input wire logic [1:0] i_lower_byte_en_n,
	input wire logic [1:0] i_addr_load_n,
	input wire logic [1:0] i_count_advance_n,
	input wire logic [1:0] i_count_clear_n,
	input wire logic [1:0] i_output_latency_sel,
	input wire logic [1:0] i_output_en_n,
	input wire logic [ADDR_W-1:0] i_addr [2],
	input wire logic [DATA_W-1:0] i_data [2],
	output logic [DATA_W-1:0] o_data [2],
	output logic [1:0] o_data_upper_oe_n,
	output logic [1:0] o_data_lower_oe_n,
	output logic [1:0] o_standby
);
	localparam int HB = DATA_W / 2;

	// per-port state, kept as one packed struct per port
	typedef struct packed {
		logic [DATA_W-1:0] dout;
		logic up_on;
		logic lo_on;
		logic [DATA_W-1:0] pipe_d;
		logic pipe_up;
		logic pipe_lo;
		logic [ADDR_W-1:0] raddr;
		logic rd_up;
		logic rd_lo;
		logic strap;
		sdpr_pwr_t pwr;
		logic [1:0] sel_run;
		logic standby;
	} sdpr_port_t;

	sdpr_port_t st_reg [2];
	sdpr_port_t st_next [2];
	logic [ADDR_W-1:0] acc_addr [2];
	logic [DATA_W-1:0] rdata [2];
	logic [1:0] we;
	logic [1:0] upper_we;
	logic [1:0] sel;
	logic [ADDR_W-1:0] rd_addr [2];

	// select pair decode, used by write strobes and state logic
	function automatic logic sdpr_selected(input logic s0_n, input logic s1);
		return !s0_n && s1;
	endfunction

	// identical counter per port so either may lead a transfer
	for (genvar p = 0; p < 2; p++) begin : g_port
		sdpr_addr_counter #(
			.ADDR_W(ADDR_W)
		) u_cnt (
			.i_clk(i_clk),
			.i_sys_rst(i_sys_rst),
			.i_ext_addr(i_addr[p]),
			.i_addr_load_n(i_addr_load_n[p]),
			.i_count_advance_n(i_count_advance_n[p]),
			.i_count_clear_n(i_count_clear_n[p]),
			.o_access_addr(acc_addr[p])
		);
		assign sel[p] = sdpr_selected(i_primary_select_n[p],
			i_secondary_select[p]);
		// write lands at the edge; stands for the self-timed pulse
		assign we[p] = sel[p] && !i_read_write[p]
			&& !i_lower_byte_en_n[p];
		assign upper_we[p] = sel[p] && !i_read_write[p]
			&& !i_upper_byte_en_n[p];
		// array reads the address registered at the last edge
		assign rd_addr[p] = st_reg[p].raddr;
	end

	sdpr_mem_array #(
		.ADDR_W(ADDR_W),
		.DATA_W(DATA_W),
		.DEPTH(DEPTH)
	) u_mem (
		.i_clk(i_clk),
		.i_we(we),
		.i_upper_we(upper_we),
		.i_waddr(acc_addr),
		.i_wdata(i_data),
		.i_raddr(rd_addr),
		.o_rdata(rdata)
	);

	// next state of each port
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			logic rd;
			logic awake;
			logic [DATA_W-1:0] src_d;
			logic src_up;
			logic src_lo;
			rd = 1'b0;
			awake = 1'b0;
			src_d = '0;
			src_up = 1'b0;
			src_lo = 1'b0;
			st_next[p] = st_reg[p];
			// strap is static; sampled only to keep outputs registered
			st_next[p].strap = i_output_latency_sel[p];
			rd = sel[p] && i_read_write[p];
			st_next[p].raddr = acc_addr[p];
			// lane enables come from this cycle's controls, used next cycle
			st_next[p].rd_up = rd && !i_upper_byte_en_n[p];
			st_next[p].rd_lo = rd && !i_lower_byte_en_n[p];
			// power: one deselected cycle drops to standby
			case (st_reg[p].pwr)
				SDPR_ST_STANDBY: begin
					if (sel[p]) begin
						st_next[p].pwr = st_reg[p].strap ? SDPR_ST_WAKE
							: SDPR_ST_ACTIVE;
					end
				end
				SDPR_ST_WAKE: begin
					st_next[p].pwr = sel[p] ? SDPR_ST_ACTIVE
						: SDPR_ST_STANDBY;
				end
				SDPR_ST_ACTIVE: begin
					if (!sel[p]) begin
						st_next[p].pwr = SDPR_ST_STANDBY;
					end
				end
				default: begin
					st_next[p].pwr = SDPR_ST_STANDBY;
				end
			endcase
			st_next[p].standby = st_next[p].pwr == SDPR_ST_STANDBY;
			st_next[p].sel_run = sel[p] ? ((st_reg[p].sel_run == 2'h3)
				? 2'h3 : st_reg[p].sel_run + 2'h1) : 2'h0;
			// pipelined port blanks outputs until it is fully awake
			awake = !st_reg[p].strap || (st_reg[p].pwr == SDPR_ST_ACTIVE);
			// flow-through reads the array at the registered address
			src_d = rdata[p];
			src_up = st_reg[p].rd_up && awake;
			src_lo = st_reg[p].rd_lo && awake;
			st_next[p].pipe_d = src_d;
			st_next[p].pipe_up = src_up;
			st_next[p].pipe_lo = src_lo;
			if (st_reg[p].strap) begin
				// extra register stage for pipelined output
				st_next[p].dout = st_reg[p].pipe_d;
				st_next[p].up_on = st_reg[p].pipe_up;
				st_next[p].lo_on = st_reg[p].pipe_lo;
			end else begin
				st_next[p].dout = src_d;
				st_next[p].up_on = src_up;
				st_next[p].lo_on = src_lo;
			end
		end
	end

	// every state bit moves on the rising edge only
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int p = 0; p < 2; p++) begin
				st_reg[p] <= '0;
				st_reg[p].pwr <= SDPR_ST_STANDBY;
				st_reg[p].standby <= 1'b1;
				st_reg[p].raddr <= `SDPR_ADDR_RST;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				st_reg[p] <= st_next[p];
			end
		end
	end

	// outputs straight from flip-flops; output enable is a plain gate by the pad
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			o_data[p] = st_reg[p].dout;
			o_standby[p] = st_reg[p].standby;
			// output enable is async, so it merges after the flops
			o_data_upper_oe_n[p] = !(st_reg[p].up_on
				&& !i_output_en_n[p]);
			o_data_lower_oe_n[p] = !(st_reg[p].lo_on
				&& !i_output_en_n[p]);
		end
	end

	// checks on the left port; pipelined checks watch the right port
	deselect_blanks_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!sel[0] |=> !st_reg[0].rd_up && !st_reg[0].rd_lo)
		else $error("deselect did not blank lanes");
	lane_split_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_upper_byte_en_n[0] |=> !st_reg[0].rd_up)
		else $error("disabled upper lane was armed");
	load_addr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_addr_load_n[0] && i_count_advance_n[0] && i_count_clear_n[0]
		|=> st_reg[0].raddr == $past(i_addr[0]))
		else $error("external address not captured");
	advance_addr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_addr_load_n[0] && !i_count_advance_n[0] && i_count_clear_n[0]
		|=> st_reg[0].raddr == ADDR_W'($past(st_reg[0].raddr) + 1))
		else $error("counter did not advance by one");
	hold_addr_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_addr_load_n[0] && i_count_advance_n[0] && i_count_clear_n[0]
		|=> $stable(st_reg[0].raddr))
		else $error("address moved while holding");
	clear_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_count_clear_n[0] |=> st_reg[0].raddr == '0)
		else $error("clear did not reach address zero");
	standby_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!sel[0] |=> o_standby[0])
		else $error("no standby after deselect");
	pipe_wake_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st_reg[1].strap && o_standby[1] && sel[1] |=> !st_reg[1].pipe_up
		&& !st_reg[1].pipe_lo)
		else $error("pipelined port woke too early");
	flow_latency_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!st_reg[0].strap && !i_output_latency_sel[0]
		|=> o_data[0] == $past(rdata[0]))
		else $error("flow-through data not one clock");
	lower_lane_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_lower_byte_en_n[0] |=> !st_reg[0].rd_lo)
		else $error("disabled lower lane was armed");
	read_lane_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sel[0] && i_read_write[0] && !i_upper_byte_en_n[0]
		|=> st_reg[0].rd_up)
		else $error("selected read did not arm upper lane");
	oe_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_output_en_n[0] |-> o_data_upper_oe_n[0]
		&& o_data_lower_oe_n[0])
		else $error("output enable did not release lanes");
	flow_wake_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!st_reg[0].strap && o_standby[0] && sel[0]
		|=> !o_standby[0])
		else $error("flow-through port slow to wake");
	out_state_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!st_reg[0].strap
		|=> st_reg[0].up_on == $past(st_reg[0].rd_up))
		else $error("output state not from previous controls");

	// same rules on the right port, which the bench runs pipelined
	right_blank_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!sel[1] |=> !st_reg[1].rd_up && !st_reg[1].rd_lo)
		else $error("right deselect did not blank lanes");
	right_lane_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_upper_byte_en_n[1] |=> !st_reg[1].rd_up)
		else $error("right disabled upper lane was armed");
	right_lower_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_lower_byte_en_n[1] |=> !st_reg[1].rd_lo)
		else $error("right disabled lower lane was armed");
	right_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		sel[1] && i_read_write[1] && !i_upper_byte_en_n[1]
		|=> st_reg[1].rd_up)
		else $error("right selected read did not arm upper lane");
	right_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_addr_load_n[1] && i_count_advance_n[1] && i_count_clear_n[1]
		|=> st_reg[1].raddr == $past(i_addr[1]))
		else $error("right external address not captured");
	right_advance_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		i_addr_load_n[1] && !i_count_advance_n[1] && i_count_clear_n[1]
		|=> st_reg[1].raddr == ADDR_W'($past(st_reg[1].raddr) + 1))
		else $error("right counter did not advance by one");
	right_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_addr_load_n[1] && i_count_advance_n[1] && i_count_clear_n[1]
		|=> $stable(st_reg[1].raddr))
		else $error("right address moved while holding");
	right_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_count_clear_n[1] |=> st_reg[1].raddr == '0)
		else $error("right clear did not reach address zero");
	right_standby_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		!sel[1] |=> o_standby[1])
		else $error("right port no standby after deselect");

	// pipelined port: blanked while waking, two selected cycles needed, data one stage behind
	pipe_blank_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st_reg[1].strap && st_reg[1].pwr == SDPR_ST_WAKE
		|=> !st_reg[1].pipe_up && !st_reg[1].pipe_lo)
		else $error("waking port passed lane enables");
	wake_run_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		st_reg[1].strap && st_reg[1].pwr == SDPR_ST_ACTIVE
		|-> st_reg[1].sel_run >= `SDPR_WAKE_CYCLES)
		else $error("pipelined port active too soon");
	pipe_latency_a: assert property (@(posedge i_clk)
		disable iff (i_sys_rst)
		st_reg[1].strap && i_output_latency_sel[1]
		|=> o_data[1] == $past(st_reg[1].pipe_d))
		else $error("pipelined data skipped its stage");
endmodule // sdpr_dual_port_ram

// *** testbench/sdpr_host_model.sv ***
// host-side bus master model driving one ram port
`timescale 1ns/1ps
`include "sdpr_consts.svh"
module sdpr_host_model (
	input wire logic i_clk,
	output logic [7:0] o_ctl,
	output logic [`SDPR_ADDR_W-1:0] o_addr,
	output logic [`SDPR_DATA_W-1:0] o_data
);
	// ctl: sel_n, sel, read, upper_n, lower_n, load_n, advance_n, clear_n
	initial begin
		o_ctl = 8'he3;
		o_addr = '0;
		o_data = '0;
	end
	// one request a cycle, changed just after the edge and held
	task automatic op(input logic [7:0] c, input logic [14:0] a,
		input logic [17:0] d);
		@(posedge i_clk);
		#1;
		o_ctl = c;
		o_addr = a;
		// data lines not written show a toggling pattern, never stale data
		o_data = c[5] ? ~o_data : d;
	endtask
endmodule // sdpr_host_model

// *** testbench/tb_top.sv ***
// self-checking bench for the dual-port ram port pair
`timescale 1ns/1ps
`include "sdpr_consts.svh"
module tb_top;
	localparam logic [7:0] c_rd = 8'h63;
	localparam logic [7:0] c_wr = 8'h43;
	localparam logic [7:0] c_nop = 8'he3;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [1:0] oe_n = 2'h0;
	int miscompares = 0;
	int num_checks = 0;
	wire logic [7:0] ctl [2];
	wire logic [14:0] addr [2];
	wire logic [17:0] wdata [2];
	logic [17:0] rdata [2];
	logic [1:0] up_oe_n;
	logic [1:0] lo_oe_n;
	logic [1:0] standby;
	// 40 MHz
	always #12.5 i_clk = ~i_clk;
	sdpr_host_model u_left (.i_clk(i_clk), .o_ctl(ctl[0]), .o_addr(addr[0]),
		.o_data(wdata[0]));
	sdpr_host_model u_right (.i_clk(i_clk), .o_ctl(ctl[1]), .o_addr(addr[1]),
		.o_data(wdata[1]));
	// left port flow-through, right port pipelined
	sdpr_dual_port_ram u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_primary_select_n({ctl[1][7], ctl[0][7]}),
		.i_secondary_select({ctl[1][6], ctl[0][6]}),
		.i_read_write({ctl[1][5], ctl[0][5]}),
		.i_upper_byte_en_n({ctl[1][4], ctl[0][4]}),
		.i_lower_byte_en_n({ctl[1][3], ctl[0][3]}),
		.i_addr_load_n({ctl[1][2], ctl[0][2]}),
		.i_count_advance_n({ctl[1][1], ctl[0][1]}),
		.i_count_clear_n({ctl[1][0], ctl[0][0]}),
		.i_output_latency_sel(2'h2), .i_output_en_n(oe_n),
		.i_addr(addr), .i_data(wdata), .o_data(rdata),
		.o_data_upper_oe_n(up_oe_n), .o_data_lower_oe_n(lo_oe_n),
		.o_standby(standby));
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic go(input int p, input logic [7:0] c, input logic [14:0] a,
		input logic [17:0] d);
		if (p == 1) u_right.op(c, a, d);
		else u_left.op(c, a, d);
	endtask
	// wait out the port's output latency, then sample 2 ns after the edge
	task automatic settle(input int p);
		// request edge, then one more (flow) or two more (pipelined)
		repeat (2 + p) @(posedge i_clk);
		#2;
	endtask
	// pipelined port is asked twice so a wake-up cycle never hides data
	task automatic rd(input int p, input logic [7:0] c, input logic [14:0] a,
		input logic [17:0] exp, input logic [1:0] oe);
		go(p, c, a, 18'h0_0000);
		if (p == 1) go(p, c, a, 18'h0_0000);
		settle(p);
		check(18'({up_oe_n[p], lo_oe_n[p]}), 18'(oe));
		check(rdata[p] & {{9{~oe[1]}}, {9{~oe[0]}}}, exp);
	endtask
	task automatic done(input string s);
		$display("%0t test %s finished", $time, s);
	endtask
	task automatic t_addr;
		go(0, c_wr, 15'h7fff, 18'h2_a5c3);
		go(0, c_wr, 15'h0010, 18'h1_5a3c);
		rd(0, c_rd, 15'h7fff, 18'h2_a5c3, 2'h0);
		rd(0, c_rd, 15'h0010, 18'h1_5a3c, 2'h0);
		go(0, c_wr, 15'h0100, 18'h0_0111);
		go(0, c_wr, 15'h0101, 18'h0_0222);
		go(0, c_wr, 15'h0200, 18'h0_0aaa);
		go(0, 8'h45, 15'h0000, 18'h0_0bbb);
		rd(0, c_rd, 15'h0201, 18'h0_0bbb, 2'h0);
		rd(0, c_rd, 15'h0100, 18'h0_0111, 2'h0);
		rd(0, 8'h65, 15'h0000, 18'h0_0222, 2'h0);
		// a held advance keeps counting, so reload a known word to hold on
		go(0, c_wr, 15'h0103, 18'h0_0333);
		rd(0, 8'h67, 15'h0200, 18'h0_0333, 2'h0);
		settle(0);
		check(rdata[0], 18'h0_0333);
		go(0, 8'h46, 15'h0300, 18'h0_0cdc);
		rd(0, 8'h66, 15'h0300, 18'h0_0cdc, 2'h0);
		rd(0, c_rd, 15'h0000, 18'h0_0cdc, 2'h0);
		done("address");
	endtask
	task automatic t_lanes;
		go(0, c_wr, 15'h0400, 18'h1_2345);
		rd(0, 8'h73, 15'h0400, 18'h0_0145, 2'h2);
		rd(0, 8'h6b, 15'h0400, 18'h1_2200, 2'h1);
		rd(0, 8'h23, 15'h0400, 18'h0_0000, 2'h3);
		rd(0, c_nop, 15'h0400, 18'h0_0000, 2'h3);
		check(18'(standby[0]), 18'h0_0001);
		rd(0, c_rd, 15'h0400, 18'h1_2345, 2'h0);
		check(18'(standby[0]), 18'h0_0000);
		rd(1, 8'h6b, 15'h0400, 18'h1_2200, 2'h1);
		go(1, c_nop, 15'h0400, 18'h0_0000);
		go(1, c_rd, 15'h0400, 18'h0_0000);
		// first selected read after standby stays blanked
		repeat (3) @(posedge i_clk);
		#2;
		check(18'({up_oe_n[1], lo_oe_n[1]}), 18'h0_0003);
		@(posedge i_clk);
		#2;
		check(rdata[1], 18'h1_2345);
		check(18'({up_oe_n[1], lo_oe_n[1]}), 18'h0_0000);
		done("lanes");
	endtask
	task automatic t_cross;
		go(0, c_wr, 15'h0500, 18'h2_0505);
		rd(1, c_rd, 15'h0500, 18'h2_0505, 2'h0);
		go(1, c_wr, 15'h0501, 18'h1_1501);
		rd(0, c_rd, 15'h0501, 18'h1_1501, 2'h0);
		rd(1, c_rd, 15'h0500, 18'h2_0505, 2'h0);
		done("cross");
	endtask
	task automatic t_turn;
		go(0, c_wr, 15'h0600, 18'h0_1616);
		rd(0, c_rd, 15'h0600, 18'h0_1616, 2'h0);
		go(0, c_nop, 15'h0600, 18'h0_0000);
		settle(0);
		check(18'({up_oe_n[0], lo_oe_n[0]}), 18'h0_0003);
		go(0, c_wr, 15'h0600, 18'h3_2727);
		go(0, c_wr, 15'h0600, 18'h3_2727); // rewrite after turnaround
		rd(0, c_rd, 15'h0600, 18'h3_2727, 2'h0);
		@(posedge i_clk);
		#1;
		oe_n[0] = 1'b1;
		#1;
		check(18'({up_oe_n[0], lo_oe_n[0]}), 18'h0_0003);
		@(posedge i_clk);
		#1;
		oe_n[0] = 1'b0;
		#1;
		check(18'({up_oe_n[0], lo_oe_n[0]}), 18'h0_0000);
		done("turnaround");
	endtask
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog: whole run needs about 110 cycles
	initial begin
		#(25 * 3000);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge i_clk);
		#1;
		check(18'({standby, up_oe_n, lo_oe_n}), 18'h0_003f);
		i_sys_rst = 1'b0;
		t_addr();
		t_lanes();
		t_cross();
		t_turn();
		complete_run();
	end
endmodule // tb_top
